// File: ssf_dev.sv
// Device end: APB register slave, transmit buffer and shifter, receiver, and the status-one flags.
// Assumes APB on pclk; the link line from the remote node is asynchronous.
//
// What this block does
// [R1] Transmit-empty sets at reset and on buffer-to-shifter move
// [R2] Transmit-empty clears: status read, then data write
// [R3] Transmit-complete sets when buffer empty, shifter idle
// [R4] Complete clears: status read, then write, enable, break
// [R5] Receive-full sets when character reaches data register
// [R6] Receive-full clears: status read, then data read
// [R7] Idle sets after ten high bit times
// [R8] Select zero: idle counting starts after start bit
// [R9] Select one: idle counting starts after stop bit
// [R10] Idle clears: status read, then data read
// [R11] Idle rearms only after a new received character
// [R12] Overrun sets on unread data; new character dropped
// [R13] Overrun clears: status read, then data read
// [R14] Seven start samples, three per bit; disagreement flags noise
// [R15] Noise clears: status read, then data read
// [R16] Framing error when stop bit samples low
// [R17] Framing clears: status read, then data read
// [R18] Parity error when enabled and parity mismatches
// [R19] Parity clears: status read, then data read
// [R20] Status register read-only; writes ignored
// [R21] Each enabled set flag requests an interrupt
// [R22] Clear affects only flags seen by prior status read
`timescale 1ns/100ps
module ssf_dev
	import ssf_pkg::*;
#(
	parameter logic [7:0] SAMPLE_DIV = ssf_pkg::SAMPLE_DIV_DEFAULT
)
(
	// Clock and reset
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	// APB slave
	input  wire logic [ssf_pkg::ADDR_W-1:0] paddr,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	// Serial link
	ssf_link_if.dev                       link,
	// Interrupt request
	output logic                          irq_request
);
	import ssf_pkg::*;

	logic [7:0] div_r;
	logic       sample_tick_r;
	logic [3:0] tx_phase_r;
	logic       bit_tick;
	logic [7:0] flags_r;
	logic [7:0] seen_r;
	logic [7:0] ctl_r;
	logic [3:0] cfg_r;
	logic [7:0] rx_data_r;
	logic [7:0] tx_buf_r;
	logic [8:0] tx_shift_r;
	logic [3:0] tx_left_r;
	logic       txd_r;
	logic       preamble_pend_r;
	logic       idle_ok_r;
	logic       access, done, mapped;
	logic       data_wr, data_rd, stat_rd, ctl_wr;
	logic       tc_trigger, tx_load, break_on;
	logic [7:0] set_v, clr_v, clr_mask;
	logic       rx_done, rx_noise, rx_framing, rx_parity, rx_quiet;
	logic [7:0] rx_data;

	////////////////////////////////////////////////////////////////////////////////
	// Bit timing: sample enable and free-running transmit bit enable
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			div_r         <= 8'h00;
			sample_tick_r <= 1'b0;
			tx_phase_r    <= 4'h0;
		end
		else
		begin
			sample_tick_r <= (div_r == SAMPLE_DIV - 8'h01);
			div_r         <= (div_r == SAMPLE_DIV - 8'h01) ? 8'h00 : div_r + 8'h01;
			if (sample_tick_r)
				tx_phase_r <= tx_phase_r + 4'h1;
		end

	assign bit_tick = sample_tick_r && (tx_phase_r == PHASE_LAST);

	////////////////////////////////////////////////////////////////////////////////
	// APB: one wait state, effects at the edge that samples pready high
	assign access  = psel && penable && !pready;
	assign done    = psel && penable && pready;
	assign mapped  = paddr == OFS_STATUS_ONE || paddr == OFS_DATA_REGISTER ||
	                 paddr == OFS_CONTROL_TWO || paddr == OFS_LINE_CONFIG;
	assign stat_rd = done && !pwrite && paddr == OFS_STATUS_ONE;
	assign data_wr = done && pwrite && paddr == OFS_DATA_REGISTER;
	assign data_rd = done && !pwrite && paddr == OFS_DATA_REGISTER;
	assign ctl_wr  = done && pwrite && paddr == OFS_CONTROL_TWO;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready  <= access;
			pslverr <= access && !mapped;
			if (access)
			begin
				prdata <= 32'h0000_0000;
				if (!pwrite)
					unique case (paddr)
						OFS_STATUS_ONE:    prdata[7:0] <= flags_r;
						OFS_DATA_REGISTER: prdata[7:0] <= rx_data_r;
						OFS_CONTROL_TWO:   prdata[7:0] <= ctl_r;
						OFS_LINE_CONFIG:   prdata[3:0] <= cfg_r;
						default:           prdata      <= 32'h0000_0000;
					endcase
			end
		end

	// Status writes fall through: no register takes them
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			ctl_r <= CONTROL_RESET;
			cfg_r <= CONFIG_RESET;
		end
		else if (done && pwrite)
		begin
			if (paddr == OFS_CONTROL_TWO)
				ctl_r <= pwdata[7:0];
			if (paddr == OFS_LINE_CONFIG)
				cfg_r <= pwdata[3:0];                                           // R20
		end

	////////////////////////////////////////////////////////////////////////////////
	// Transmitter: buffer, shifter, queued preamble and break
	assign tc_trigger = ctl_wr && ((pwdata[CTL_TX_ENABLE] && !ctl_r[CTL_TX_ENABLE]) ||
	                               pwdata[CTL_SEND_BREAK]);                     // R4
	assign break_on   = ctl_r[CTL_SEND_BREAK] && ctl_r[CTL_TX_ENABLE];
	assign tx_load    = bit_tick && tx_left_r <= 4'h1 && ctl_r[CTL_TX_ENABLE] &&
	                    (preamble_pend_r || break_on || !flags_r[FLG_TX_EMPTY]);

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			tx_buf_r        <= 8'h00;
			tx_shift_r      <= 9'h1FF;
			tx_left_r       <= 4'h0;
			txd_r           <= 1'b1;
			preamble_pend_r <= 1'b0;
		end
		else
		begin
			if (data_wr)
				tx_buf_r <= pwdata[7:0];
			if (ctl_wr && pwdata[CTL_TX_ENABLE] && !ctl_r[CTL_TX_ENABLE])
				preamble_pend_r <= 1'b1;
			if (tx_load)
			begin
				// Preamble first, then break, then data
				if (preamble_pend_r)
				begin
					{tx_shift_r, txd_r} <= 10'h3FF;
					preamble_pend_r     <= 1'b0;
				end
				else if (break_on)
					{tx_shift_r, txd_r} <= 10'h000;
				else
					{tx_shift_r, txd_r} <= ssf_frame(tx_buf_r, cfg_r[CFG_PARITY_EN], cfg_r[CFG_PARITY_ODD]);
				tx_left_r <= FRAME_BITS;
			end
			else if (bit_tick && tx_left_r != 4'h0)
			begin
				txd_r      <= tx_shift_r[0];
				tx_shift_r <= {1'b1, tx_shift_r[8:1]};
				tx_left_r  <= tx_left_r - 4'h1;
				if (tx_left_r == 4'h1)
					txd_r <= 1'b1;
			end
		end

	assign link.dev_txd = txd_r;

	////////////////////////////////////////////////////////////////////////////////
	// Receiver
	ssf_rx u_rx (
		.pclk          (pclk),
		.presetn       (presetn),
		.sample_tick   (sample_tick_r),
		.line_in       (link.node_txd),
		.parity_enable (cfg_r[CFG_PARITY_EN]),
		.parity_odd    (cfg_r[CFG_PARITY_ODD]),
		.quiet_sel     (cfg_r[CFG_QUIET_SEL]),
		.char_done     (rx_done),
		.char_data     (rx_data),
		.char_noise    (rx_noise),
		.char_framing  (rx_framing),
		.char_parity   (rx_parity),
		.quiet_seen    (rx_quiet)
	);

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			rx_data_r <= 8'h00;
		else if (rx_done && !flags_r[FLG_RX_FULL])
			rx_data_r <= rx_data;                                               // R5 R12

	////////////////////////////////////////////////////////////////////////////////
	// Status flags: set wins over clear in the same cycle
	always_comb
	begin
		set_v = 8'h00;
		set_v[FLG_TX_EMPTY] = tx_load && !preamble_pend_r && !break_on;         // R1
		// A data write or queued preamble or break this cycle means the transmitter is not idle
		set_v[FLG_TX_DONE]  = flags_r[FLG_TX_EMPTY] && tx_left_r == 4'h0 && !data_wr && !tc_trigger &&
		                      !preamble_pend_r && !break_on;                     // R3
		set_v[FLG_OVERRUN]  = rx_done && flags_r[FLG_RX_FULL];                  // R12
		if (rx_done && !flags_r[FLG_RX_FULL])
		begin
			set_v[FLG_RX_FULL] = 1'b1;                                          // R5
			set_v[FLG_NOISE]   = rx_noise;                                      // R14
			set_v[FLG_FRAMING] = rx_framing;                                    // R16
			set_v[FLG_PARITY]  = rx_parity;                                     // R18
		end
		set_v[FLG_IDLE] = rx_quiet && idle_ok_r;                                // R7 R11
		clr_mask = 8'h00;
		if (data_wr)
			clr_mask = clr_mask | 8'hC0;                                        // R2 R4
		if (tc_trigger)
			clr_mask[FLG_TX_DONE] = 1'b1;                                       // R4
		if (data_rd)
			clr_mask = clr_mask | 8'h3F;                                        // R6 R10 R13 R15 R17 R19
		clr_v = clr_mask & seen_r;                                              // R22
	end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			flags_r   <= STATUS_RESET;                                          // R1 R3
			seen_r    <= 8'h00;
			idle_ok_r <= 1'b1;
		end
		else
		begin
			flags_r <= (flags_r & ~clr_v) | set_v;
			if (stat_rd)
				seen_r <= prdata[7:0];                                          // R22
			else
				seen_r <= seen_r & ~clr_mask;
			if (set_v[FLG_RX_FULL])
				idle_ok_r <= 1'b1;
			else if (clr_v[FLG_IDLE])
				idle_ok_r <= 1'b0;                                              // R11
		end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			irq_request <= 1'b0;
		else
			irq_request <= |(flags_r & {ctl_r[7:4], {4{cfg_r[CFG_ERROR_IE]}}}); // R21

endmodule : ssf_dev

// File: ssf_pkg.sv
// Constants, register map and frame helpers shared by both ends of the serial status-flag link.
// Assumes a 32-bit APB register side and 8-bit data frames with one start and one stop bit.
package ssf_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register map, byte addresses on APB
	localparam int         ADDR_W            = 12;
	localparam logic [11:0] OFS_STATUS_ONE    = 12'h000;
	localparam logic [11:0] OFS_DATA_REGISTER = 12'h004;
	localparam logic [11:0] OFS_CONTROL_TWO   = 12'h008;
	localparam logic [11:0] OFS_LINE_CONFIG   = 12'h00C;

	// Status flag positions
	localparam int FLG_TX_EMPTY = 7;
	localparam int FLG_TX_DONE  = 6;
	localparam int FLG_RX_FULL  = 5;
	localparam int FLG_IDLE     = 4;
	localparam int FLG_OVERRUN  = 3;
	localparam int FLG_NOISE    = 2;
	localparam int FLG_FRAMING  = 1;
	localparam int FLG_PARITY   = 0;

	// Control and line configuration positions
	localparam int CTL_TX_EMPTY_IE = 7;
	localparam int CTL_TX_DONE_IE  = 6;
	localparam int CTL_RX_FULL_IE  = 5;
	localparam int CTL_IDLE_IE     = 4;
	localparam int CTL_TX_ENABLE   = 3;
	localparam int CTL_SEND_BREAK  = 0;
	localparam int CFG_PARITY_ODD  = 0;
	localparam int CFG_PARITY_EN   = 1;
	localparam int CFG_QUIET_SEL   = 2;
	localparam int CFG_ERROR_IE    = 3;

	// Reset values
	localparam logic [7:0] STATUS_RESET  = 8'hC0;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [3:0] CONFIG_RESET  = 4'h0;

	////////////////////////////////////////////////////////////////////////////////
	// Timing: pclk cycles per sample, samples per bit
	localparam logic [7:0]  SAMPLE_DIV_DEFAULT = 8'h04;
	localparam logic [3:0]  PHASE_LAST         = 4'hF;
	localparam logic [15:0] START_SAMPLE_MASK  = 16'h0FA8;
	localparam logic [15:0] BIT_SAMPLE_MASK    = 16'h0700;
	localparam logic [2:0]  LAST_DATA_BIT      = 3'h7;
	localparam logic [3:0]  FRAME_BITS         = 4'hA;
	localparam logic [7:0]  IDLE_SAMPLES       = 8'hA0;

	typedef enum logic [1:0] {RX_HUNT, RX_START, RX_DATA, RX_STOP} ssf_rx_state_e;

	// Parity bit that makes the character even or odd
	function automatic logic ssf_parity(input logic [6:0] d, input logic odd);
		return (^d) ^ odd;
	endfunction : ssf_parity

	// Frame sent LSB first: start, eight data (MSB replaced by parity when enabled), stop
	function automatic logic [9:0] ssf_frame(input logic [7:0] d, input logic pen, input logic odd);
		logic msb;
		msb = pen ? ssf_parity(d[6:0], odd) : d[7];
		return {1'b1, msb, d[6:0], 1'b0};
	endfunction : ssf_frame

endpackage : ssf_pkg

// File: ssf_link_if.sv
// Serial link between the device end and the remote node: one line each way.
// Both ends drive their line from a flip-flop; idle level is high.
`timescale 1ns/100ps
interface ssf_link_if;
	logic dev_txd;
	logic node_txd;

	modport dev  (output dev_txd, input node_txd);
	modport node (input dev_txd, output node_txd);
endinterface : ssf_link_if

// File: ssf_rx.sv
// Oversampling frame receiver with noise, framing, parity and idle-line detection.
// Assumes a one-cycle sample_tick at sixteen times the bit rate; the line input is asynchronous.
`timescale 1ns/100ps
module ssf_rx
	import ssf_pkg::*;
(
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Sampling and line
	input  wire logic       sample_tick,
	input  wire logic       line_in,
	// Options
	input  wire logic       parity_enable,
	input  wire logic       parity_odd,
	input  wire logic       quiet_sel,
	// Results
	output logic            char_done,
	output logic [7:0]      char_data,
	output logic            char_noise,
	output logic            char_framing,
	output logic            char_parity,
	output logic            quiet_seen
);
	import ssf_pkg::*;

	logic          sync1_r;
	logic          line_r;
	logic          prev_r;
	ssf_rx_state_e state_r;
	logic [3:0]    phase_r;
	logic [2:0]    bit_idx_r;
	logic [2:0]    ones_r;
	logic [2:0]    taken_r;
	logic          noise_r;
	logic [7:0]    shift_r;
	logic [7:0]    quiet_cnt_r;
	logic          armed_r;
	logic          sample_now;
	logic          bit_val;
	logic          bit_noisy;
	logic          count_ok;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			sync1_r <= 1'b1;
			line_r  <= 1'b1;
		end
		else
		begin
			sync1_r <= line_in;
			line_r  <= sync1_r;
		end

	always_comb
	begin
		unique case (state_r)
			RX_START: sample_now = sample_tick & START_SAMPLE_MASK[phase_r];
			RX_DATA,
			RX_STOP:  sample_now = sample_tick & BIT_SAMPLE_MASK[phase_r];
			RX_HUNT:  sample_now = 1'b0;
		endcase
	end

	assign bit_val   = {ones_r, 1'b0} > {1'b0, taken_r};
	assign bit_noisy = (ones_r != 3'h0) && (ones_r != taken_r);                // R14

	////////////////////////////////////////////////////////////////////////////////
	// Frame sequencer
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			state_r      <= RX_HUNT;
			prev_r       <= 1'b1;
			phase_r      <= 4'h0;
			bit_idx_r    <= 3'h0;
			ones_r       <= 3'h0;
			taken_r      <= 3'h0;
			noise_r      <= 1'b0;
			shift_r      <= 8'h00;
			char_done    <= 1'b0;
			char_data    <= 8'h00;
			char_noise   <= 1'b0;
			char_framing <= 1'b0;
			char_parity  <= 1'b0;
		end
		else
		begin
			char_done <= 1'b0;
			if (sample_tick)
				prev_r <= line_r;
			if (sample_now)
			begin
				ones_r  <= ones_r + {2'b00, line_r};
				taken_r <= taken_r + 3'h1;
			end
			if (state_r == RX_HUNT)
			begin
				if (sample_tick && prev_r && !line_r)
				begin
					state_r <= RX_START;
					phase_r <= 4'h0;
					ones_r  <= 3'h0;
					taken_r <= 3'h0;
				end
			end
			else if (sample_tick)
			begin
				phase_r <= phase_r + 4'h1;
				if (phase_r == PHASE_LAST)
				begin
					ones_r  <= 3'h0;
					taken_r <= 3'h0;
					unique case (state_r)
						RX_START:
							if (bit_val)
								state_r <= RX_HUNT;
							else
							begin
								noise_r   <= bit_noisy;                             // R14
								bit_idx_r <= 3'h0;
								state_r   <= RX_DATA;
							end
						RX_DATA:
						begin
							shift_r   <= {bit_val, shift_r[7:1]};
							noise_r   <= noise_r | bit_noisy;                     // R14
							bit_idx_r <= bit_idx_r + 3'h1;
							if (bit_idx_r == LAST_DATA_BIT)
								state_r <= RX_STOP;
						end
						default:
						begin
							char_done    <= 1'b1;
							char_data    <= shift_r;
							char_noise   <= noise_r | bit_noisy;                  // R14
							char_framing <= !bit_val;                            // R16
							char_parity  <= parity_enable &&
							                (shift_r[7] != ssf_parity(shift_r[6:0], parity_odd)); // R18
							state_r      <= RX_HUNT;
						end
					endcase
				end
			end
		end

	////////////////////////////////////////////////////////////////////////////////
	// Idle-line timer, counted in samples of high level
	assign count_ok = (state_r == RX_HUNT) ||
	                  (!quiet_sel && (state_r == RX_DATA || state_r == RX_STOP)); // R8 R9

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			quiet_cnt_r <= 8'h00;
			armed_r     <= 1'b0;
			quiet_seen  <= 1'b0;
		end
		else
		begin
			quiet_seen <= 1'b0;
			if (state_r == RX_HUNT && sample_tick && prev_r && !line_r)
				armed_r <= 1'b1;
			if (sample_tick)
			begin
				if (!line_r || !count_ok)
					quiet_cnt_r <= 8'h00;                                       // R8 R9
				else if (quiet_cnt_r != IDLE_SAMPLES)
					quiet_cnt_r <= quiet_cnt_r + 8'h01;
				if (line_r && count_ok && armed_r && quiet_cnt_r == IDLE_SAMPLES - 8'h01)
				begin
					quiet_seen <= 1'b1;                                         // R7
					armed_r    <= 1'b0;
				end
			end
		end

endmodule : ssf_rx

// File: ssf_node.sv
// Remote serial node: sends user bytes as frames and reports each received frame.
// Assumes the same bit timing and parity setting as the device end.
`timescale 1ns/100ps
module ssf_node
	import ssf_pkg::*;
#(
	parameter logic [7:0] SAMPLE_DIV = ssf_pkg::SAMPLE_DIV_DEFAULT
)
(
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Serial link
	ssf_link_if.node        link,
	// Line options
	input  wire logic       parity_enable,
	input  wire logic       parity_odd,
	// Send side
	input  wire logic       send_valid,
	input  wire logic [7:0] send_data,
	output logic            send_ready,
	// Receive side
	output logic            recv_valid,
	output logic [7:0]      recv_data,
	output logic            recv_noise,
	output logic            recv_framing,
	output logic            recv_parity
);
	import ssf_pkg::*;

	logic [7:0] div_r;
	logic       sample_tick_r;
	logic [3:0] phase_r;
	logic       bit_tick;
	logic [7:0] hold_r;
	logic [8:0] shift_r;
	logic [3:0] left_r;
	logic       txd_r;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			div_r         <= 8'h00;
			sample_tick_r <= 1'b0;
			phase_r       <= 4'h0;
		end
		else
		begin
			sample_tick_r <= (div_r == SAMPLE_DIV - 8'h01);
			div_r         <= (div_r == SAMPLE_DIV - 8'h01) ? 8'h00 : div_r + 8'h01;
			if (sample_tick_r)
				phase_r <= phase_r + 4'h1;
		end

	assign bit_tick = sample_tick_r && (phase_r == PHASE_LAST);

	////////////////////////////////////////////////////////////////////////////////
	// One-byte holding stage ahead of the shifter; ready low while it is full
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			hold_r     <= 8'h00;
			send_ready <= 1'b1;
			shift_r    <= 9'h1FF;
			left_r     <= 4'h0;
			txd_r      <= 1'b1;
		end
		else
		begin
			if (send_valid && send_ready)
			begin
				hold_r     <= send_data;
				send_ready <= 1'b0;
			end
			if (bit_tick && left_r <= 4'h1 && !send_ready)
			begin
				{shift_r, txd_r} <= ssf_frame(hold_r, parity_enable, parity_odd);
				left_r           <= FRAME_BITS;
				send_ready       <= 1'b1;
			end
			else if (bit_tick && left_r != 4'h0)
			begin
				txd_r   <= (left_r == 4'h1) ? 1'b1 : shift_r[0];
				shift_r <= {1'b1, shift_r[8:1]};
				left_r  <= left_r - 4'h1;
			end
		end

	assign link.node_txd = txd_r;

	ssf_rx u_rx (
		.pclk          (pclk),
		.presetn       (presetn),
		.sample_tick   (sample_tick_r),
		.line_in       (link.dev_txd),
		.parity_enable (parity_enable),
		.parity_odd    (parity_odd),
		.quiet_sel     (1'b0),
		.char_done     (recv_valid),
		.char_data     (recv_data),
		.char_noise    (recv_noise),
		.char_framing  (recv_framing),
		.char_parity   (recv_parity),
		.quiet_seen    ()
	);

endmodule : ssf_node

// File: ssf_properties.sv
// Concurrent checks on the APB side of the device end and on both link lines.
// Assumes the bench clock and reset; instantiated beside the link, no bind.
`timescale 1ns/100ps
module ssf_properties
	import ssf_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Link lines
	input  wire logic        dev_txd,
	input  wire logic        node_txd,
	// APB
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	import ssf_pkg::*;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic rd_stat;
	assign rd_stat = pready && !pwrite && paddr == OFS_STATUS_ONE;

	////////////////////////////////////////////////////////////////////////////////
	a_access_wait: assert property (psel && penable && !pready |=> pready)
		else $error("access not answered after one wait state");
	a_ready_single: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	a_ready_cause: assert property ($rose(pready) |-> $past(psel) && $past(penable))
		else $error("ready without a request");
	a_status_width: assert property (rd_stat |-> prdata[31:8] == 24'h0)
		else $error("status read carries bits above the flags");
	a_unmapped_err: assert property (pready && paddr > OFS_LINE_CONFIG |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_reset_idle: assert property ($rose(presetn) |-> dev_txd && node_txd)
		else $error("line not idle after reset");
	// Start bit must last at least half a bit at the shortest divider
	a_dev_start: assert property ($fell(dev_txd) |-> (!dev_txd) [*8])
		else $error("device start bit too short");
	a_node_start: assert property ($fell(node_txd) |-> (!node_txd) [*8])
		else $error("node start bit too short");
endmodule : ssf_properties

// File: serial_status_flags_bench.sv
// Self-checking bench: device end and remote node joined by one link.
// Assumes SAMPLE_DIV of 1, so one bit lasts 16 pclk cycles.
`timescale 1ns/100ps
module serial_status_flags_bench;
	import ssf_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, v;
	logic        pen, podd, send_valid, send_ready, recv_valid, rn, rf, rp;
	logic [7:0]  send_data, recv_data, b;
	int          n_fail, n_compared, seed, i;

	ssf_link_if ssf_link_if_inst ();
	ssf_dev #(.SAMPLE_DIV(8'h01)) ssf_dev_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(ssf_link_if_inst), .irq_request(irq));
	ssf_node #(.SAMPLE_DIV(8'h01)) ssf_node_inst (.pclk(pclk), .presetn(presetn), .link(ssf_link_if_inst),
		.parity_enable(pen), .parity_odd(podd), .send_valid(send_valid), .send_data(send_data),
		.send_ready(send_ready), .recv_valid(recv_valid), .recv_data(recv_data), .recv_noise(rn),
		.recv_framing(rf), .recv_parity(rp));
	ssf_properties ssf_properties_inst (.pclk(pclk), .presetn(presetn), .dev_txd(ssf_link_if_inst.dev_txd),
		.node_txd(ssf_link_if_inst.node_txd), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	////////////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		if (n_fail == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check

	// Device checks even parity; a sender of the other sense makes a parity error
	function automatic logic [31:0] exp_parity_err(input logic [7:0] d, input logic odd);
		logic sent;
		sent = (^d[6:0]) ^ odd;
		return {31'h0, sent != (^d[6:0])};
	endfunction : exp_parity_err

	// Entered just after a rising edge; idles one cycle so the next setup never collides
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		v = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic rs();
		apb(1'b0, OFS_STATUS_ONE, 32'h0);
	endtask : rs

	task automatic rdd();
		apb(1'b0, OFS_DATA_REGISTER, 32'h0);
	endtask : rdd

	task automatic poll(input int pos);
		rs();
		while (v[pos] !== 1'b1)
			rs();
	endtask : poll

	task automatic send(input logic [7:0] d);
		send_valid <= 1'b1;
		send_data <= d;
		@(posedge pclk);
		while (send_ready !== 1'b1)
			@(posedge pclk);
		send_valid <= 1'b0;
		@(posedge pclk);
	endtask : send

	task automatic catch_byte();
		while (recv_valid !== 1'b1)
			@(posedge pclk);
	endtask : catch_byte

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// Whole run needs about 3800 cycles
	initial
	begin
		repeat (40000) @(posedge pclk);
		n_fail++;
		close_out();
	end

	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, send_valid, send_data, pen, podd} = '0;
		{n_fail, n_compared} = '0;
		seed = 22;
		presetn = 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rs();
		check(v & 32'h80, 32'h80);
		check(v & 32'h40, 32'h40);
		check({31'h0, irq}, 32'h0);
		apb(1'b0, 12'h010, 32'h0);
		check(v, 32'h0);
		apb(1'b1, OFS_STATUS_ONE, 32'h0);
		rs();
		check(v, 32'h0000_00C0);
		// Enable queues a preamble, so the first byte waits in the buffer
		apb(1'b1, OFS_CONTROL_TWO, 32'h8);
		rs();
		check(v & 32'h40, 32'h0);
		b = 8'($random(seed));
		apb(1'b1, OFS_DATA_REGISTER, {24'h0, b});
		rs();
		check(v & 32'h80, 32'h0);
		catch_byte();
		check({21'h0, rn, rf, rp, recv_data}, {24'h0, b});
		for (i = 0; i < 3; i++)
		begin
			poll(FLG_TX_EMPTY);
			b = 8'($random(seed));
			apb(1'b1, OFS_DATA_REGISTER, {24'h0, b});
			rs();
			check(v & 32'h40, 32'h0);
			catch_byte();
			check({21'h0, rn, rf, rp, recv_data}, {24'h0, b});
		end
		poll(FLG_TX_DONE);
		check(v & 32'hC0, 32'hC0);
		// Break: node sees all zeros with a low stop bit
		apb(1'b1, OFS_CONTROL_TWO, 32'h9);
		rs();
		check(v & 32'h40, 32'h0);
		catch_byte();
		check({21'h0, rn, rf, rp, recv_data}, 32'h0000_0200);
		apb(1'b1, OFS_CONTROL_TWO, 32'h8);
		for (i = 0; i < 3; i++)
		begin
			b = 8'($random(seed));
			send(b);
			poll(FLG_RX_FULL);
			check(v & 32'h2F, 32'h20);
			rdd();
			check(v, {24'h0, b});
			rs();
			check(v & 32'h20, 32'h0);
		end
		// All-ones character: only the count start point differs between selects
		for (i = 0; i < 2; i++)
		begin
			apb(1'b1, OFS_LINE_CONFIG, i ? 32'h4 : 32'h0);
			send(8'hFF);
			poll(FLG_RX_FULL);
			rdd();
			repeat (48) @(posedge pclk);
			rs();
			check(v & 32'h10, i ? 32'h0 : 32'h10);
			repeat (160) @(posedge pclk);
			rs();
			check(v & 32'h10, 32'h10);
			rdd();
			repeat (200) @(posedge pclk);
			rs();
			check(v & 32'h10, 32'h0);
		end
		b = 8'($random(seed));
		send(b);
		send(8'h5A);
		poll(FLG_OVERRUN);
		check(v & 32'h28, 32'h28);
		rdd();
		check(v, {24'h0, b});
		rs();
		check(v & 32'h28, 32'h0);
		// Character lands after the status read, so the data read must not clear it
		send(8'h3C);
		repeat (200) @(posedge pclk);
		rdd();
		rs();
		check(v & 32'h20, 32'h20);
		rdd();
		for (i = 0; i < 2; i++)
		begin
			pen <= 1'b1;
			podd <= (i == 0);
			apb(1'b1, OFS_LINE_CONFIG, 32'h2);
			send(8'h11);
			poll(FLG_RX_FULL);
			check(v & 32'h1, exp_parity_err(8'h11, podd));
			rdd();
			rs();
			check(v & 32'h1, 32'h0);
		end
		apb(1'b1, OFS_CONTROL_TWO, 32'h48);
		rs();
		check({31'h0, irq}, 32'h1);
		close_out();
	end
endmodule : serial_status_flags_bench
